// [hdl/dual_idac_update_control.sv]
// Purpose: Register file and update scheduling for two twelve-bit current DACs.
// Assumes: Classic Wishbone slave, 8-bit registers in the low lane of 32-bit words.
// Notes: One wait state on every access; unmapped addresses answer with zero.
// How it works
// - Left justified, high byte holds the top eight bits of the word.
// - Right justified, high byte bits 3-0 hold top four bits; 7-4 are zero.
// - Left justified, low byte bits 7-4 hold bottom four bits; 3-0 are zero.
// - Right justified, low byte holds the bottom eight bits of the word.
// - Control bit 7 enables the converter.
// - Source codes 000 to 011 update on timer 0 to 3 overflow.
// - Codes 100, 101, 110 update on rising, falling or any start edge.
// - Code 111 updates on a write to the high data byte.
// - Control bit 3 is reserved, reads zero, software writes zero.
// - Control bit 2 selects left or right justification.
// - Control bits 1-0 select full scale 0.25, 0.5, 1 or 2 mA.
// - First converter drives P0.0; second drives P0.0 or P0.1 by merge select.
// - With both converters disabled the pins stay ordinary GPIO.
// - An enabled converter takes its pin: driver and pull-up off, analog on.
// - Both enabled with merge set puts both outputs on P0.0.
// - On-write mode holds low byte writes until the high byte write.
// - Timer modes hold data until overflow; timers 2, 3 follow their width mode.
// - Edge modes hold data and copy both bytes on the chosen edge.
//
// Local design decision: the Wishbone slave port.
`timescale 1ns/10ps
module dual_idac_update_control (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // Wishbone slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [9:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  // Timer overflow events
  input  wire logic             timer_overflow_0,
  input  wire logic             timer_overflow_1,
  input  wire logic             timer2_low_overflow,
  input  wire logic             timer2_high_overflow,
  input  wire logic             timer2_split_mode,
  input  wire logic             timer3_low_overflow,
  input  wire logic             timer3_high_overflow,
  input  wire logic             timer3_split_mode,
  // External start pin
  input  wire logic             external_convert_start,
  // Converter cores
  output logic      [11:0]      first_current_dac_word,
  output logic      [11:0]      second_current_dac_word,
  output logic      [1:0]       dac_update_strobe,
  output logic      [1:0]       converter_enable_bits,
  output logic      [1:0]       dac_a_fullscale_select,
  output logic      [1:0]       dac_b_fullscale_select,
  // Pin routing
  output logic                  p0_0_analog_connect,
  output logic                  p0_1_analog_connect,
  output logic                  second_dac_on_p0_0
);

  logic [1:0][7:0]  data_low;
  logic [1:0][7:0]  data_high;
  logic [1:0][7:0]  control;
  logic             output_merge_select;

  logic [7:0]       index;
  logic             aligned;
  logic             request;
  logic             bus_write;
  logic [7:0]       read_value;
  logic [3:0]       timer_events;
  logic             start_rise;
  logic             start_fall;
  logic [1:0][11:0] latch_words;
  logic [1:0]       strobes;

  assign index   = wb_adr_i[9:2];
  assign aligned = (wb_adr_i[1:0] == 2'b00);
  assign request = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  // Writes land on the edge where the master sees ack, matching the classic handshake.
  assign bus_write = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0] & aligned;

  // Timers 2 and 3 pick the overflow that matches their counting width.
  assign timer_events[0] = timer_overflow_0;
  assign timer_events[1] = timer_overflow_1;
  assign timer_events[2] = timer2_split_mode ? timer2_low_overflow : timer2_high_overflow;
  assign timer_events[3] = timer3_split_mode ? timer3_low_overflow : timer3_high_overflow;

  start_edge_detect start_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .pin      (external_convert_start),
    .rise     (start_rise),
    .fall     (start_fall)
  );

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_channel

      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          data_low[ch] <= idac_pkg::DATA_RESET;
        end else if (bus_write && index == idac_pkg::IDX_LOW[ch]) begin
          data_low[ch] <= wb_dat_i[7:0];
        end
      end

      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          data_high[ch] <= idac_pkg::DATA_RESET;
        end else if (bus_write && index == idac_pkg::IDX_HIGH[ch]) begin
          data_high[ch] <= wb_dat_i[7:0];
        end
      end

      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          control[ch] <= idac_pkg::CTRL_RESET;
        end else if (bus_write && index == idac_pkg::IDX_CTRL[ch]) begin
          control[ch] <= wb_dat_i[7:0] & idac_pkg::CTRL_WRITE_MASK;
        end
      end

      update_channel channel (
        .core_clk       (core_clk),
        .rst_n          (rst_n),
        .update_source  (control[ch][idac_pkg::SOURCE_MSB:idac_pkg::SOURCE_LSB]),
        .right_justify  (control[ch][idac_pkg::JUSTIFY_BIT]),
        .high_byte      (data_high[ch]),
        .low_byte       (data_low[ch]),
        .high_write     (bus_write && index == idac_pkg::IDX_HIGH[ch]),
        .high_wdata     (wb_dat_i[7:0]),
        .timer_overflow (timer_events),
        .start_rise     (start_rise),
        .start_fall     (start_fall),
        .latch_word     (latch_words[ch]),
        .update_strobe  (strobes[ch])
      );

      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          converter_enable_bits[ch] <= 1'b0;
        end else begin
          converter_enable_bits[ch] <= control[ch][idac_pkg::ENABLE_BIT];
        end
      end

    end
  endgenerate

  assign first_current_dac_word  = latch_words[0];
  assign second_current_dac_word = latch_words[1];
  assign dac_update_strobe       = strobes;

  // The analog core decodes the code into its current range.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      dac_a_fullscale_select <= idac_pkg::CTRL_RESET[idac_pkg::FULLSCALE_MSB:0];
      dac_b_fullscale_select <= idac_pkg::CTRL_RESET[idac_pkg::FULLSCALE_MSB:0];
    end else begin
      dac_a_fullscale_select <= control[0][idac_pkg::FULLSCALE_MSB:0];
      dac_b_fullscale_select <= control[1][idac_pkg::FULLSCALE_MSB:0];
    end
  end

  // Only the merge select bit of the reference control register lives here.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      output_merge_select <= idac_pkg::MERGE_RESET;
    end else if (bus_write && index == idac_pkg::IDX_REFERENCE_CONTROL) begin
      output_merge_select <= wb_dat_i[idac_pkg::MERGE_BIT];
    end
  end

  // A connect output high means driver and pull-up off, converter on the pin.
  // Routing follows the registered enables, so a pin switches one cycle after them.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      p0_0_analog_connect <= 1'b0;
      p0_1_analog_connect <= 1'b0;
      second_dac_on_p0_0  <= 1'b0;
    end else begin
      p0_0_analog_connect <= converter_enable_bits[0]
                           | (converter_enable_bits[1] & output_merge_select);
      p0_1_analog_connect <= converter_enable_bits[1] & ~output_merge_select;
      second_dac_on_p0_0  <= converter_enable_bits[1] & output_merge_select;
    end
  end

  // Data bytes keep every written bit; the unused nibble is hidden on read.
  always_comb begin
    read_value = 8'h00;
    for (int i = 0; i < 2; i++) begin
      if (index == idac_pkg::IDX_LOW[i]) begin
        read_value = control[i][idac_pkg::JUSTIFY_BIT]
                   ? data_low[i]
                   : {data_low[i][7:4], 4'h0};
      end
      if (index == idac_pkg::IDX_HIGH[i]) begin
        read_value = control[i][idac_pkg::JUSTIFY_BIT]
                   ? {4'h0, data_high[i][3:0]}
                   : data_high[i];
      end
      if (index == idac_pkg::IDX_CTRL[i]) begin
        read_value = control[i];
      end
    end
    if (index == idac_pkg::IDX_REFERENCE_CONTROL) begin
      read_value = {output_merge_select, 7'h00};
    end
    if (!aligned) begin
      read_value = 8'h00;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= request;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (request) begin
      wb_dat_o <= {24'h00_0000, read_value};
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence read_of(logic [7:0] idx, logic cond);
    request && !wb_we_i && aligned && index == idx && cond;
  endsequence

  sequence ctrl_write_a(logic [7:0] value_mask);
    bus_write && index == idac_pkg::IDX_DAC_A_CONTROL && |(wb_dat_i[7:0] & value_mask);
  endsequence

  reserved_reads_zero_a: assert property (
    read_of(idac_pkg::IDX_DAC_B_CONTROL, 1'b1) |=> wb_ack_o && !wb_dat_o[3])
    else $error("reserved control bit read as one");

  left_high_read_a: assert property (
    read_of(idac_pkg::IDX_DAC_A_DATA_HIGH, !control[0][2])
      |=> wb_dat_o[7:0] == $past(data_high[0]))
    else $error("left justified high byte read wrong");

  right_high_read_a: assert property (
    read_of(idac_pkg::IDX_DAC_A_DATA_HIGH, control[0][2]) |=> wb_dat_o[7:4] == 4'h0)
    else $error("right justified high byte upper nibble not zero");

  left_low_read_a: assert property (
    read_of(idac_pkg::IDX_DAC_B_DATA_LOW, !control[1][2]) |=> wb_dat_o[3:0] == 4'h0)
    else $error("left justified low byte lower nibble not zero");

  right_low_read_a: assert property (
    read_of(idac_pkg::IDX_DAC_A_DATA_LOW, control[0][2])
      |=> wb_dat_o[7:0] == $past(data_low[0]))
    else $error("right justified low byte read wrong");

  enable_follows_a: assert property (
    ctrl_write_a(8'h80) |=> ##1 converter_enable_bits[0])
    else $error("enable bit did not enable the converter");

  fullscale_follows_a: assert property (
    bus_write && index == idac_pkg::IDX_DAC_A_CONTROL
      |=> ##1 dac_a_fullscale_select == $past(wb_dat_i[1:0], 2))
    else $error("full scale select did not follow the control write");

  low_write_held_a: assert property (
    bus_write && index == idac_pkg::IDX_DAC_A_DATA_LOW && control[0][6:4] == 3'b111
      |=> $stable(first_current_dac_word))
    else $error("low byte write changed the output in on-write mode");

  rise_edge_update_a: assert property (
    start_rise && control[1][6:4] == 3'b100 |=> dac_update_strobe[1])
    else $error("rising start edge did not update the converter");

  fall_ignored_a: assert property (
    start_fall && !start_rise && control[1][6:4] == 3'b100 |=> !dac_update_strobe[1])
    else $error("falling edge updated a rising-edge converter");

  timer2_width_a: assert property (
    control[1][6:4] == 3'b010 && timer2_split_mode && timer2_low_overflow
      |=> dac_update_strobe[1])
    else $error("8-bit timer 2 overflow did not update the converter");

  gpio_release_a: assert property (
    converter_enable_bits == 2'b00 |=> !p0_0_analog_connect && !p0_1_analog_connect)
    else $error("pin taken while both converters are disabled");

  first_on_p0_a: assert property (
    converter_enable_bits[0] |=> p0_0_analog_connect)
    else $error("first converter not connected to P0.0");

  second_on_p1_a: assert property (
    converter_enable_bits[1] && !output_merge_select |=> p0_1_analog_connect)
    else $error("second converter not connected to P0.1");

  merged_outputs_a: assert property (
    converter_enable_bits == 2'b11 && output_merge_select
      |=> p0_0_analog_connect && second_dac_on_p0_0 && !p0_1_analog_connect)
    else $error("merged outputs not routed to P0.0");

endmodule

// [hdl/idac_pkg.sv]
// Purpose: Shared constants and helpers for the dual current DAC update control.
// Assumes: Eight-bit registers, one per aligned bus word, byte address is four times the index.
// Notes: The data word is twelve bits wide for both converters.
package idac_pkg;

  localparam logic [7:0] IDX_DAC_A_DATA_LOW      = 8'h96;
  localparam logic [7:0] IDX_DAC_A_DATA_HIGH     = 8'h97;
  localparam logic [7:0] IDX_DAC_A_CONTROL       = 8'hb9;
  localparam logic [7:0] IDX_DAC_B_CONTROL       = 8'hb5;
  localparam logic [7:0] IDX_DAC_B_DATA_LOW      = 8'hf4;
  localparam logic [7:0] IDX_DAC_B_DATA_HIGH     = 8'hf5;
  localparam logic [7:0] IDX_REFERENCE_CONTROL   = 8'hd1;

  localparam logic [1:0][7:0] IDX_LOW  = {IDX_DAC_B_DATA_LOW, IDX_DAC_A_DATA_LOW};
  localparam logic [1:0][7:0] IDX_HIGH = {IDX_DAC_B_DATA_HIGH, IDX_DAC_A_DATA_HIGH};
  localparam logic [1:0][7:0] IDX_CTRL = {IDX_DAC_B_CONTROL, IDX_DAC_A_CONTROL};

  localparam int ENABLE_BIT    = 7;
  localparam int SOURCE_MSB    = 6;
  localparam int SOURCE_LSB    = 4;
  localparam int RESERVED_BIT  = 3;
  localparam int JUSTIFY_BIT   = 2;
  localparam int FULLSCALE_MSB = 1;
  localparam int MERGE_BIT     = 7;

  localparam logic [7:0] CTRL_WRITE_MASK = 8'hf7;
  localparam logic [7:0] CTRL_RESET      = 8'h73;
  localparam logic [7:0] DATA_RESET      = 8'h00;
  localparam logic       MERGE_RESET     = 1'b0;

  typedef enum logic [2:0] {
    SRC_TIMER0   = 3'b000,
    SRC_TIMER1   = 3'b001,
    SRC_TIMER2   = 3'b010,
    SRC_TIMER3   = 3'b011,
    SRC_RISE     = 3'b100,
    SRC_FALL     = 3'b101,
    SRC_ANY_EDGE = 3'b110,
    SRC_ON_WRITE = 3'b111
  } update_source_t;

  function automatic logic [11:0] make_word(input logic [7:0] high,
                                            input logic [7:0] low,
                                            input logic       right);
    make_word = right ? {high[3:0], low} : {high, low[7:4]};
  endfunction

endpackage

// [hdl/start_edge_detect.sv]
// Purpose: Brings the external conversion-start pin into the core clock and finds its edges.
// Assumes: The pin is asynchronous to core_clk.
// Notes: Each edge gives one single-cycle pulse, two edges of delay after the pin moves.
`timescale 1ns/10ps
module start_edge_detect (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Pin and edge pulses
  input  wire logic pin,
  output logic      rise,
  output logic      fall
);

  logic meta;
  logic stable;
  logic prev;

  // Only stable feeds the detector, so a metastable sample never makes a pulse.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      meta   <= 1'b0;
      stable <= 1'b0;
      prev   <= 1'b0;
    end else begin
      meta   <= pin;
      stable <= meta;
      prev   <= stable;
    end
  end

  assign rise = stable & ~prev;
  assign fall = ~stable & prev;

  // A fast pin can give a rise and then a fall on consecutive cycles, so each kind is checked alone.
  single_rise_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    rise |=> !rise)
    else $error("start rising pulse lasted more than one cycle");

  single_fall_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    fall |=> !fall)
    else $error("start falling pulse lasted more than one cycle");

endmodule

// [hdl/update_channel.sv]
// Purpose: Staging-to-latch transfer for one current DAC.
// Assumes: Timer overflow pulses and the write strobe are on core_clk.
// Notes: The latch is the converter input word and is held between update events.
`timescale 1ns/10ps
module update_channel (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Configuration
  input  wire logic [2:0]  update_source,
  input  wire logic        right_justify,
  // Staged bytes and high byte write
  input  wire logic [7:0]  high_byte,
  input  wire logic [7:0]  low_byte,
  input  wire logic        high_write,
  input  wire logic [7:0]  high_wdata,
  // Update events
  input  wire logic [3:0]  timer_overflow,
  input  wire logic        start_rise,
  input  wire logic        start_fall,
  // Converter side
  output logic      [11:0] latch_word,
  output logic             update_strobe
);

  logic        trigger;
  logic [11:0] next_word;

  always_comb begin
    trigger   = 1'b0;
    next_word = idac_pkg::make_word(high_byte, low_byte, right_justify);
    unique case (idac_pkg::update_source_t'(update_source))
      idac_pkg::SRC_TIMER0,
      idac_pkg::SRC_TIMER1,
      idac_pkg::SRC_TIMER2,
      idac_pkg::SRC_TIMER3: begin
        trigger = timer_overflow[update_source[1:0]];
      end
      idac_pkg::SRC_RISE: begin
        trigger = start_rise;
      end
      idac_pkg::SRC_FALL: begin
        trigger = start_fall;
      end
      idac_pkg::SRC_ANY_EDGE: begin
        trigger = start_rise | start_fall;
      end
      idac_pkg::SRC_ON_WRITE: begin
        // The new high byte bypasses its register so the update is not a cycle late.
        trigger   = high_write;
        next_word = idac_pkg::make_word(high_wdata, low_byte, right_justify);
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      latch_word <= 12'h000;
    end else if (trigger) begin
      latch_word <= next_word;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      update_strobe <= 1'b0;
    end else begin
      update_strobe <= trigger;
    end
  end

  on_write_latch_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (update_source == 3'b111 && high_write) |=> latch_word == $past(next_word))
    else $error("high byte write did not load the latch");

  timer_latch_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!update_source[2] && timer_overflow[update_source[1:0]])
      |=> (latch_word == $past(next_word)) && update_strobe)
    else $error("selected timer overflow did not load the latch");

  held_latch_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !trigger |=> $stable(latch_word) && !update_strobe)
    else $error("latch changed without an update event");

endmodule

// [verification/event_source_model.sv]
// Purpose: Stand-in for the timers and the start pin that feed the DAC block.
// Assumes: Overflow pulses last one core_clk cycle, as real timer overflows do.
// Notes: The pin is a plain level, so the bench decides where its edges fall.
`timescale 1ns/10ps
module event_source_model (
  // Clock
  input  wire logic core_clk,
  // Events
  output logic [5:0] overflow,
  output logic       split_mode,
  output logic       start_pin
);
  initial begin
    overflow   = 6'h00;
    split_mode = 1'b0;
    start_pin  = 1'b0;
  end

  // Order of bits: t0, t1, t2 low, t2 high, t3 low, t3 high.
  task automatic fire(input int k);
    @(posedge core_clk);
    overflow[k] <= 1'b1;
    @(posedge core_clk);
    overflow[k] <= 1'b0;
  endtask

  task automatic set_level(input logic s, input logic p);
    @(posedge core_clk);
    split_mode <= s;
    start_pin  <= p;
  endtask
endmodule

// [verification/test_dual_idac_update_control.sv]
// Purpose: Self-checking bench for the dual current DAC update control.
// Assumes: The bench is the bus master; the event model plays timers and pin.
// Notes: Expected words are worked out here from the two data layouts.
`timescale 1ns/10ps
module test_dual_idac_update_control;
  logic        core_clk = 1'b0;
  logic        rst_n    = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i  = 1'b0;
  logic [9:0]  wb_adr_i = 10'h000;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [5:0]  ovf;
  logic        split;
  logic        pin;
  logic [11:0] word_a;
  logic [11:0] word_b;
  logic [1:0]  strobe;
  logic [1:0]  enables;
  logic [1:0]  fs_a;
  logic [1:0]  fs_b;
  logic        p00;
  logic        p01;
  logic        on00;
  int          n_errors     = 0;
  int          total_checks = 0;
  int          cycles       = 0;
  int          n_upd        = 0;

  always #20 core_clk = ~core_clk;

  dual_idac_update_control dual_idac_update_control_inst (
    .core_clk(core_clk), .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .timer_overflow_0(ovf[0]), .timer_overflow_1(ovf[1]),
    .timer2_low_overflow(ovf[2]), .timer2_high_overflow(ovf[3]),
    .timer2_split_mode(split),
    .timer3_low_overflow(ovf[4]), .timer3_high_overflow(ovf[5]),
    .timer3_split_mode(split),
    .external_convert_start(pin),
    .first_current_dac_word(word_a), .second_current_dac_word(word_b),
    .dac_update_strobe(strobe), .converter_enable_bits(enables),
    .dac_a_fullscale_select(fs_a), .dac_b_fullscale_select(fs_b),
    .p0_0_analog_connect(p00), .p0_1_analog_connect(p01),
    .second_dac_on_p0_0(on00)
  );

  event_source_model event_source_model_inst (
    .core_clk(core_clk), .overflow(ovf), .split_mode(split), .start_pin(pin)
  );

  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // A hang anywhere ends the run as a failure rather than stalling it.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      print_verdict();
    end
  end

  always @(posedge core_clk) begin
    if (strobe[1] === 1'b1) n_upd++;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] wd,
                    output logic [31:0] rd);
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h00_0000, wd};
    // Only the bench timeout ends a wait that never sees ack.
    do begin
      @(posedge core_clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [31:0] d;
    wb(1'b1, idx, wd, d);
  endtask

  task automatic rdc(input string name, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    wb(1'b0, idx, 8'h00, d);
    chk(name, d, exp);
  endtask

  // Timer steps: source, split mode, overflow bit, update expected.
  logic [15:0] tmr [9] = '{16'h0010, 16'h0001, 16'h1011, 16'h2020, 16'h2031,
                           16'h2121, 16'h3150, 16'h3141, 16'h3051};
  // Pin steps: source, pin level, update expected.
  logic [11:0] edg [6] = '{12'h510, 12'h501, 12'h411, 12'h400, 12'h611, 12'h601};
  // Routing: enable a, enable b, merge, then P0.0, P0.1, second on P0.0.
  logic [5:0]  rte [6] = '{6'o00, 6'o44, 6'o22, 6'o35, 6'o75, 6'o66};

  initial begin
    logic [11:0] exp_b;
    logic [7:0]  hi;
    logic [15:0] e;
    int          u0;
    exp_b = 12'h000;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    rdc("b_control", idac_pkg::IDX_DAC_B_CONTROL, 32'h0000_0073);
    rdc("a_low", idac_pkg::IDX_DAC_A_DATA_LOW, 32'h0000_0000);
    rdc("a_high", idac_pkg::IDX_DAC_A_DATA_HIGH, 32'h0000_0000);
    rdc("b_low", idac_pkg::IDX_DAC_B_DATA_LOW, 32'h0000_0000);
    rdc("b_high", idac_pkg::IDX_DAC_B_DATA_HIGH, 32'h0000_0000);
    rdc("unmapped", 8'h10, 32'h0000_0000);
    chk("fs_a", fs_a, 2'b11);
    // Software keeps the reserved bit at zero on every control write.
    wr(idac_pkg::IDX_DAC_B_CONTROL, 8'hf7);
    rdc("reserved", idac_pkg::IDX_DAC_B_CONTROL, 32'h0000_00f7);
    chk("enables", enables, 2'b10);
    for (int i = 0; i < 4; i++) begin
      wr(idac_pkg::IDX_DAC_B_CONTROL, 8'h70 | i[7:0]);
      repeat (2) @(posedge core_clk);
      #1 chk("fs_b", fs_b, i[1:0]);
    end
    wr(idac_pkg::IDX_DAC_A_DATA_LOW, 8'hab);
    #1 chk("held low", word_a, 12'h000);
    wr(idac_pkg::IDX_DAC_A_DATA_HIGH, 8'hcd);
    #1 chk("word_a", word_a, 12'hcda);
    chk("strobe", strobe, 2'b01);
    rdc("left low", idac_pkg::IDX_DAC_A_DATA_LOW, 32'h0000_00a0);
    wr(idac_pkg::IDX_DAC_A_CONTROL, 8'h77);
    wr(idac_pkg::IDX_DAC_A_DATA_HIGH, 8'h5e);
    #1 chk("right word", word_a, 12'heab);
    rdc("right high", idac_pkg::IDX_DAC_A_DATA_HIGH, 32'h0000_000e);
    rdc("right low", idac_pkg::IDX_DAC_A_DATA_LOW, 32'h0000_00ab);
    for (int k = 0; k < 9; k++) begin
      e  = tmr[k];
      hi = 8'h20 + k[7:0];
      event_source_model_inst.set_level(e[8], 1'b0);
      wr(idac_pkg::IDX_DAC_B_CONTROL, {1'b1, e[14:12], 4'h3});
      wr(idac_pkg::IDX_DAC_B_DATA_LOW, 8'h10);
      wr(idac_pkg::IDX_DAC_B_DATA_HIGH, hi);
      #1 chk("staged", word_b, exp_b);
      event_source_model_inst.fire(int'(e[7:4]));
      if (e[0]) exp_b = {hi, 4'h1};
      #1 chk("timer word", word_b, exp_b);
    end
    for (int k = 0; k < 6; k++) begin
      e  = {4'h0, edg[k]};
      hi = 8'h40 + k[7:0];
      wr(idac_pkg::IDX_DAC_B_CONTROL, {1'b1, e[10:8], 4'h3});
      wr(idac_pkg::IDX_DAC_B_DATA_LOW, 8'h50);
      wr(idac_pkg::IDX_DAC_B_DATA_HIGH, hi);
      u0 = n_upd;
      event_source_model_inst.set_level(1'b0, e[4]);
      repeat (6) @(posedge core_clk);
      if (e[0]) exp_b = {hi, 4'h5};
      #1 chk("edge word", word_b, exp_b);
      chk("edge count", n_upd - u0, e[0]);
    end
    // The bench plays software that has set the crossbar skip bits of both pins.
    for (int k = 0; k < 6; k++) begin
      wr(idac_pkg::IDX_DAC_A_CONTROL, {rte[k][5], 7'h73});
      wr(idac_pkg::IDX_DAC_B_CONTROL, {rte[k][4], 7'h73});
      wr(idac_pkg::IDX_REFERENCE_CONTROL, {rte[k][3], 7'h00});
      repeat (3) @(posedge core_clk);
      #1 chk("pins", {p00, p01, on00}, rte[k][2:0]);
    end
    print_verdict();
  end
endmodule
